// ### design/bipl_pkg.sv
// Package for the board interrupt priority logic: timing constants and carrier types.
// Assumes a single 125 MHz system clock; warning and reset cycle counts are derived from CLK_HZ.
package bipl_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ           = 125_000_000;
  localparam int unsigned WARN_TIME_MS     = 500;
  localparam int unsigned RESET_TIME_MS    = 1000;
  localparam int unsigned WARN_CYCLES      = (CLK_HZ / 1000) * WARN_TIME_MS;
  localparam int unsigned RESET_CYCLES     = (CLK_HZ / 1000) * RESET_TIME_MS;
  localparam int unsigned SYSRST_CYCLES    = 16;

  // ************************************************************
  // Levels and reset values
  // ************************************************************
  localparam logic [2:0] LEVEL_NONE        = 3'h0;
  localparam logic [2:0] LEVEL_RST         = 3'h0;
  localparam logic [2:0] VECTOR_RST        = 3'h0;

  // Active-high requests of the seven autovector levels, bit n-1 is level n
  typedef struct packed {
    logic l7;
    logic l6;
    logic l5;
    logic l4;
    logic l3;
    logic l2;
    logic l1;
  } bipl_req_t;

  // Level-three sub-sources, bit n is extended priority n
  typedef struct packed {
    logic disk0;
    logic disk1;
    logic xio5;
    logic xio4;
    logic xio3;
    logic xio2;
    logic special_port;
    logic floppy;
  } bipl_sub_t;

  typedef enum logic [1:0] {
    WD_RUN,
    WD_WARN,
    WD_RESET
  } bipl_wd_state_t;
endpackage

// ### design/bipl_top.sv
// Board interrupt priority logic: seven autovector levels, level-three scan, watchdog.
// Assumes all request pins are asynchronous; the processor samples the encoded level.
//
// Function
// - Level seven from the non-maskable button or the watchdog early warning.
// - Level six when the active-low power-low warning is asserted.
// - Level five is reserved and driven only by the expansion slot request.
// - Level four when any serial channel requests service.
// - Level three carries system control requests from the counter/parallel unit.
// - Level three sub-sources ranked disk0 seven down to floppy zero.
// - Level two is reserved and driven only by the expansion slot request.
// - Level one when memory error logic reports a correctable error.
// - Half a second without retrigger raises the early warning interrupt.
// - One second without retrigger generates a full system reset.
`timescale 1ns/1ps
`default_nettype none
module bipl_top #(
  parameter int unsigned WARN_CYC  = bipl_pkg::WARN_CYCLES,
  parameter int unsigned RESET_CYC = bipl_pkg::RESET_CYCLES,
  parameter int unsigned N_SERIAL  = 4
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                nmi_button_n,
  input  wire logic                power_low_warning_n,
  input  wire logic                expansion_level5_n,
  input  wire logic [N_SERIAL-1:0] serial_request_n,
  input  wire logic                disk0_request_n,
  input  wire logic                disk1_request_n,
  input  wire logic                expansion_io_request5_n,
  input  wire logic                expansion_io_request4_n,
  input  wire logic                expansion_io_request3_n,
  input  wire logic                expansion_io_request2_n,
  input  wire logic                special_port_request_n,
  input  wire logic                floppy_request_n,
  input  wire logic                expansion_level2_n,
  input  wire logic                correctable_error_n,
  input  wire logic                watchdog_kick,
  output logic [2:0]               cpu_level,
  output logic [2:0]               counter_parallel_unit_vector,
  output logic                     counter_parallel_unit_pending,
  output logic                     watchdog_warning,
  output logic                     system_reset
);
  import bipl_pkg::*;

  localparam int NPIN = 13 + N_SERIAL;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [NPIN-1:0] raw_n;
  logic [NPIN-1:0] meta_reg;
  logic [NPIN-1:0] sync_reg;
  logic            kick_meta_reg;
  logic            kick_sync_reg;
  logic            kick_last_reg;
  logic            kick_pulse;

  assign raw_n = {nmi_button_n, power_low_warning_n, expansion_level5_n, serial_request_n,
                  disk0_request_n, disk1_request_n, expansion_io_request5_n,
                  expansion_io_request4_n, expansion_io_request3_n, expansion_io_request2_n,
                  special_port_request_n, floppy_request_n, expansion_level2_n,
                  correctable_error_n};

  // Inactive (high) after reset so no spurious request shows at release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= raw_n;
      sync_reg <= meta_reg;
    end
  end

  // Retrigger comes from a pin, so its edge is taken after two flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kick_meta_reg <= 1'b0;
      kick_sync_reg <= 1'b0;
      kick_last_reg <= 1'b0;
    end else begin
      kick_meta_reg <= watchdog_kick;
      kick_sync_reg <= kick_meta_reg;
      kick_last_reg <= kick_sync_reg;
    end
  end
  assign kick_pulse = kick_sync_reg && !kick_last_reg;

  // ************************************************************
  // Decoded sources, active high
  // ************************************************************
  wire                button_act  = !sync_reg[NPIN-1];
  wire                power_act   = !sync_reg[NPIN-2];
  wire                exp5_act    = !sync_reg[NPIN-3];
  wire [N_SERIAL-1:0] serial_act  = ~sync_reg[NPIN-4 -: N_SERIAL];
  wire                exp2_act    = !sync_reg[1];
  wire                ecc_act     = !sync_reg[0];
  bipl_sub_t          sub_act;
  bipl_req_t          req;

  assign sub_act = bipl_sub_t'(~sync_reg[9:2]);

  // ************************************************************
  // Watchdog
  // ************************************************************
  logic wd_warn;
  logic wd_reset;

  bipl_watchdog #(
    .WARN_CYC  (WARN_CYC),
    .RESET_CYC (RESET_CYC)
  ) u_watchdog (
    .clk           (clk),
    .rst           (rst),
    .kick          (kick_pulse),
    .early_warning (wd_warn),
    .reset_pulse   (wd_reset)
  );

  // ************************************************************
  // Level requests
  // ************************************************************
  assign req.l7 = button_act || wd_warn;
  assign req.l6 = power_act;
  assign req.l5 = exp5_act;
  assign req.l4 = |serial_act;
  assign req.l3 = |sub_act;
  assign req.l2 = exp2_act;
  assign req.l1 = ecc_act;

  // ************************************************************
  // Priority encoders
  // ************************************************************
  logic [2:0] level_next;
  logic [2:0] level_reg;
  logic [2:0] vector_next;
  logic [2:0] vector_reg;
  logic       pending_reg;
  logic       sysrst_reg;

  // Highest set bit wins; level is combinational of the held requests
  always_comb begin
    level_next = LEVEL_NONE;
    for (int i = 0; i < 7; i++) begin
      if (req[i]) level_next = 3'(i + 1);
    end
  end

  always_comb begin
    vector_next = VECTOR_RST;
    for (int i = 0; i < 8; i++) begin
      if (sub_act[i]) vector_next = 3'(i);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_reg   <= LEVEL_RST;
      vector_reg  <= VECTOR_RST;
      pending_reg <= 1'b0;
      sysrst_reg  <= 1'b0;
    end else begin
      level_reg   <= level_next;
      vector_reg  <= vector_next;
      pending_reg <= req.l3;
      sysrst_reg  <= wd_reset;
    end
  end

  assign cpu_level                     = level_reg;
  assign counter_parallel_unit_vector  = vector_reg;
  assign counter_parallel_unit_pending = pending_reg;
  assign watchdog_warning              = wd_warn;
  assign system_reset                  = sysrst_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  // Reset length is counted here, as sixteen repetitions would unroll too far
  logic [4:0] rst_len_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_len_reg <= 5'h0;
    end else begin
      rst_len_reg <= system_reset ? rst_len_reg + 5'h1 : 5'h0;
    end
  end

  a_level_seven: assert property (@(posedge clk) disable iff (rst)
    (button_act || wd_warn) |=> cpu_level == 3'h7)
    else $error("level seven not presented");

  a_power_level: assert property (@(posedge clk) disable iff (rst)
    (power_act && !req.l7) |=> cpu_level == 3'h6)
    else $error("power fail level wrong");

  a_exp5_only: assert property (@(posedge clk) disable iff (rst)
    ($past(level_next) == 3'h5) |-> ($past(exp5_act) && cpu_level == 3'h5))
    else $error("level five without expansion request");

  a_exp5_level: assert property (@(posedge clk) disable iff (rst)
    (exp5_act && !req.l7 && !req.l6) |=> cpu_level == 3'h5)
    else $error("expansion level five not presented");

  a_serial_level: assert property (@(posedge clk) disable iff (rst)
    (|serial_act && !(req.l7 || req.l6 || req.l5)) |=> cpu_level == 3'h4)
    else $error("serial level wrong");

  a_sysctl_pend: assert property (@(posedge clk) disable iff (rst)
    req.l3 |=> counter_parallel_unit_pending)
    else $error("system control pending missing");

  a_sysctl_level: assert property (@(posedge clk) disable iff (rst)
    (req.l3 && req[6:3] == 4'h0) |=> cpu_level == 3'h3)
    else $error("system control level wrong");

  a_pend_clear: assert property (@(posedge clk) disable iff (rst)
    !req.l3 |=> !counter_parallel_unit_pending)
    else $error("system control pending without source");

  a_disk0_top: assert property (@(posedge clk) disable iff (rst)
    sub_act.disk0 |=> counter_parallel_unit_vector == 3'h7)
    else $error("disk0 not top sub-source");

  a_disk1_rank: assert property (@(posedge clk) disable iff (rst)
    (sub_act.disk1 && !sub_act.disk0) |=> counter_parallel_unit_vector == 3'h6)
    else $error("disk1 vector wrong");

  a_xio5_rank: assert property (@(posedge clk) disable iff (rst)
    (sub_act.xio5 && !sub_act.disk0 && !sub_act.disk1) |=> counter_parallel_unit_vector == 3'h5)
    else $error("expansion io five vector wrong");

  a_xio2_rank: assert property (@(posedge clk) disable iff (rst)
    (sub_act.xio2 && sub_act[7:3] == 5'h00) |=> counter_parallel_unit_vector == 3'h2)
    else $error("expansion io two vector wrong");

  a_floppy_low: assert property (@(posedge clk) disable iff (rst)
    (sub_act == bipl_sub_t'(8'h01)) |=> counter_parallel_unit_vector == 3'h0)
    else $error("floppy vector wrong");

  a_vector_idle: assert property (@(posedge clk) disable iff (rst)
    (sub_act == bipl_sub_t'(8'h00)) |=> counter_parallel_unit_vector == VECTOR_RST)
    else $error("vector shown with no sub-source");

  a_exp2_only: assert property (@(posedge clk) disable iff (rst)
    (cpu_level == 3'h2) |-> $past(exp2_act))
    else $error("level two without expansion request");

  a_exp2_level: assert property (@(posedge clk) disable iff (rst)
    (exp2_act && req[6:2] == 5'h00) |=> cpu_level == 3'h2)
    else $error("expansion level two not presented");

  a_ecc_level: assert property (@(posedge clk) disable iff (rst)
    (req == bipl_req_t'(7'h01)) |=> cpu_level == 3'h1)
    else $error("correctable error level wrong");

  a_warn_raises: assert property (@(posedge clk) disable iff (rst)
    $rose(wd_warn) |=> cpu_level == 3'h7)
    else $error("warning did not raise level seven");

  a_warn_holds: assert property (@(posedge clk) disable iff (rst)
    (wd_warn && !kick_pulse) |=> (wd_warn || wd_reset))
    else $error("warning dropped without retrigger");

  a_kick_clears: assert property (@(posedge clk) disable iff (rst)
    (wd_warn && kick_pulse) |=> !wd_warn)
    else $error("retrigger did not clear warning");

  a_reset_follows: assert property (@(posedge clk) disable iff (rst)
    $rose(wd_reset) |=> system_reset [*8])
    else $error("system reset not held");

  a_reset_after_warn: assert property (@(posedge clk) disable iff (rst)
    $rose(wd_reset) |-> $past(wd_warn))
    else $error("system reset without early warning");

  a_reset_short: assert property (@(posedge clk) disable iff (rst)
    system_reset |-> rst_len_reg < 5'(SYSRST_CYCLES))
    else $error("system reset too long");

  a_reset_width: assert property (@(posedge clk) disable iff (rst)
    $fell(system_reset) |-> rst_len_reg == 5'(SYSRST_CYCLES))
    else $error("system reset too short");

  a_idle_zero: assert property (@(posedge clk) disable iff (rst)
    (req == bipl_req_t'(7'h00)) |=> cpu_level == LEVEL_NONE)
    else $error("level shown with no request");

  a_any_level: assert property (@(posedge clk) disable iff (rst)
    (req != bipl_req_t'(7'h00)) |=> cpu_level != LEVEL_NONE)
    else $error("pending request not presented");

  a_ecc_hidden: assert property (@(posedge clk) disable iff (rst)
    (ecc_act && req[6:1] != 6'h00) |=> cpu_level != 3'h1)
    else $error("lowest level shown over a higher one");

  a_level_hold: assert property (@(posedge clk) disable iff (rst)
    $stable(req) |=> $stable(cpu_level))
    else $error("level moved while requests held");
endmodule
`default_nettype wire

// ### design/bipl_watchdog.sv
// Watchdog supervisor: early warning after the warning time, system reset after the reset time.
// Assumes the retrigger input is already synchronous to clk and a one-cycle pulse or a level edge.
`timescale 1ns/1ps
`default_nettype none
module bipl_watchdog #(
  parameter int unsigned WARN_CYC  = bipl_pkg::WARN_CYCLES,
  parameter int unsigned RESET_CYC = bipl_pkg::RESET_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic kick,
  output logic      early_warning,
  output logic      reset_pulse
);
  import bipl_pkg::*;

  logic [31:0]    count_reg;
  logic [31:0]    count_next;
  logic [4:0]     hold_reg;
  logic [4:0]     hold_next;
  bipl_wd_state_t state_reg;
  bipl_wd_state_t state_next;
  logic           warn_hit;
  logic           reset_hit;

  // ************************************************************
  // Counting
  // ************************************************************
  assign warn_hit   = (count_reg == WARN_CYC - 1);
  assign reset_hit  = (count_reg == RESET_CYC - 1);
  assign count_next = (kick || state_reg == WD_RESET) ? 32'h0 :
                      reset_hit ? count_reg : count_reg + 32'h1;
  assign hold_next  = (state_reg == WD_RESET) ? hold_reg + 5'h1 : 5'h0;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      WD_RUN:   if (!kick && warn_hit) state_next = WD_WARN;
      WD_WARN: begin
        if (kick) state_next = WD_RUN;
        else if (reset_hit) state_next = WD_RESET;
      end
      WD_RESET: if (hold_reg == 5'(SYSRST_CYCLES - 1)) state_next = WD_RUN;
      // The fourth code is illegal; fall back to counting rather than lock up
      default:  state_next = WD_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 32'h0;
      hold_reg  <= 5'h0;
      state_reg <= WD_RUN;
    end else begin
      count_reg <= count_next;
      hold_reg  <= hold_next;
      state_reg <= state_next;
    end
  end

  // Warning holds until retriggered or the reset time is reached, so the top level is not lost before service
  assign early_warning = (state_reg == WD_WARN);
  assign reset_pulse   = (state_reg == WD_RESET);
endmodule
`default_nettype wire

// ### verification/bipl_cpu_model.sv
// Host processor model: retriggers the watchdog while the bench allows it.
// Assumes clk is the system clock and rst the system reset of the block.
`timescale 1ns/1ps
`default_nettype none
module bipl_cpu_model #(
  parameter int unsigned KICK_GAP = 20
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic kick_en,
  output logic      watchdog_kick
);
  int unsigned gap_cnt;

  // ************************************************************
  // Retrigger
  // ************************************************************
  // One-cycle pulses far apart, so every rising edge is seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_cnt       <= 0;
      watchdog_kick <= 1'b0;
    end else begin
      gap_cnt       <= (gap_cnt >= KICK_GAP) ? 0 : gap_cnt + 1;
      watchdog_kick <= kick_en && (gap_cnt == KICK_GAP);
    end
  end
endmodule
`default_nettype wire

// ### verification/board_interrupt_priority_logic_tb.sv
// Bench for the board interrupt priority logic: levels, level-three scan, watchdog.
// Assumes short watchdog counts; pin vector bit 7+i is level-three sub-source i.
`timescale 1ns/1ps
`default_nettype none
module board_interrupt_priority_logic_tb;
  import bipl_pkg::*;
  localparam int unsigned WC = 50;
  localparam int unsigned RC = 100;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        kick_en = 1'b1;
  logic        kick;
  logic [16:0] pins = '1;
  logic [2:0]  cpu_level;
  logic [2:0]  cpu_vec;
  logic        cpu_pend;
  logic        wd_warn;
  logic        sys_rst;
  int          err_count = 0;
  int          n_checks = 0;
  int          seed = 4;
  int          since_kick = 0;
  int          width;

  always #4 clk = ~clk;
  always @(posedge clk) since_kick <= kick ? 0 : since_kick + 1;

  bipl_top #(.WARN_CYC(WC), .RESET_CYC(RC), .N_SERIAL(4)) u_bipl_top (
    .clk(clk), .rst(rst), .nmi_button_n(pins[0]), .power_low_warning_n(pins[1]),
    .expansion_level5_n(pins[2]), .serial_request_n(pins[6:3]),
    .floppy_request_n(pins[7]), .special_port_request_n(pins[8]),
    .expansion_io_request2_n(pins[9]), .expansion_io_request3_n(pins[10]),
    .expansion_io_request4_n(pins[11]), .expansion_io_request5_n(pins[12]),
    .disk1_request_n(pins[13]), .disk0_request_n(pins[14]),
    .expansion_level2_n(pins[15]), .correctable_error_n(pins[16]),
    .watchdog_kick(kick), .cpu_level(cpu_level), .counter_parallel_unit_vector(cpu_vec),
    .counter_parallel_unit_pending(cpu_pend), .watchdog_warning(wd_warn),
    .system_reset(sys_rst));

  bipl_cpu_model #(.KICK_GAP(20)) u_bipl_cpu_model (
    .clk(clk), .rst(rst), .kick_en(kick_en), .watchdog_kick(kick));

  // ************************************************************
  // Expectations
  // ************************************************************
  function automatic logic [2:0] exp_vec(input logic [16:0] p);
    exp_vec = 3'h0;
    for (int i = 0; i < 8; i++) if (!p[7+i]) exp_vec = i[2:0];
  endfunction

  function automatic logic [2:0] exp_lvl(input logic [16:0] p);
    bipl_req_t r;
    r.l7 = !p[0];
    r.l6 = !p[1];
    r.l5 = !p[2];
    r.l4 = !(&p[6:3]);
    r.l3 = !(&p[14:7]);
    r.l2 = !p[15];
    r.l1 = !p[16];
    exp_lvl = 3'h0;
    for (int i = 0; i < 7; i++) if (r[i]) exp_lvl = 3'(i + 1);
  endfunction

  // ************************************************************
  // Checking
  // ************************************************************
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t %s got %b", $time, what, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Three edges of latency; the fourth leaves margin
  task automatic drive_check(input logic [16:0] p);
    @(posedge clk);
    #1;
    pins = p;
    repeat (4) @(posedge clk);
    #1;
    cmp_val(8'(cpu_level), 8'(exp_lvl(p)), "level");
    cmp_val(8'(cpu_vec), 8'(exp_vec(p)), "vector");
    cmp_bit(cpu_pend, !(&p[14:7]), "pending");
    repeat (3) @(posedge clk);
    #1;
    cmp_val(8'(cpu_level), 8'(exp_lvl(p)), "held");
  endtask

  task automatic wait_for(input bit want_rst);
    int n;
    n = 0;
    while (((want_rst ? sys_rst : wd_warn) !== 1'b1) && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 2000) begin
      err_count++;
      $display("FAIL t=%0t wait timed out", $time);
      give_verdict();
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    drive_check('1);
    for (int i = 0; i < 17; i++) drive_check(~(17'h1 << i));
    drive_check('0);
    drive_check(17'h0007f);
    for (int i = 0; i < 60; i++) drive_check(17'($random(seed)) | 17'($random(seed)));
    drive_check('1);
    repeat (200) @(posedge clk);
    #1;
    cmp_bit(wd_warn, 1'b0, "warn while kicked");
    kick_en = 1'b0;
    wait_for(1'b0);
    cmp_bit(since_kick >= WC && since_kick <= WC + 6, 1'b1, "warn time");
    repeat (3) @(posedge clk);
    #1;
    cmp_val(8'(cpu_level), 8'h07, "warn level");
    kick_en = 1'b1;
    repeat (30) @(posedge clk);
    #1;
    cmp_bit(wd_warn, 1'b0, "warn kicked away");
    cmp_val(8'(cpu_level), 8'(LEVEL_NONE), "level after kick");
    kick_en = 1'b0;
    wait_for(1'b0);
    wait_for(1'b1);
    cmp_bit(since_kick >= RC && since_kick <= RC + 6, 1'b1, "reset time");
    width = 0;
    while (sys_rst === 1'b1 && width < 100) begin
      @(posedge clk);
      #1;
      width++;
    end
    cmp_val(8'(width), 8'(SYSRST_CYCLES), "reset width");
    kick_en = 1'b1;
    repeat (45) @(posedge clk);
    #1;
    cmp_bit(wd_warn, 1'b0, "warn cleared");
    give_verdict();
  end
endmodule
`default_nettype wire
